// ---- hdl/rtcq_top.sv ----
/*
 Real-time counter: prescaler, 32/16-bit counter, calendar count, tamper input, periodic events,
 interrupt status with mask, Avalon-MM register slave.
 Assumes one clock, a synchronous active-low reset and a system pulse that marks an external reset
 which leaves this block running.
*/
// The Avalon-MM register port and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
module rtcq_top
#(
	parameter int DIV_BITS = 16
)
(
	input wire logic mclk,
	input wire logic rstn,
	input wire logic [5:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic tamperPin,
	input wire logic extResetSeen,
	output logic irq,
	output logic [7:0] periodicEvent
);
	// ------------------------------------------------------------
	// Parameter check
	// ------------------------------------------------------------
	if (DIV_BITS < 16 || DIV_BITS > 32)
		$error("DIV_BITS must lie between 16 and 32");

	// ------------------------------------------------------------
	// Declarations
	// ------------------------------------------------------------
	logic waitReq_r;
	logic [31:0] rdata_r;
	logic [31:0] rdata_nxt;
	logic [31:0] control_a_r;
	logic [31:0] control_b_r;
	logic [7:0] event_control_r;
	logic [rtcq_pkg::IRQ_BITS-1:0] intEn_r;
	logic [rtcq_pkg::IRQ_BITS-1:0] intFlag_r;
	logic [31:0] count_r;
	logic [31:0] calendar_r;
	logic [1:0] tamper_control_r;
	logic [31:0] timestamp_r;
	logic [31:0] gp_r;
	logic [31:0] backup_r;
	logic [DIV_BITS-1:0] div_r;
	logic [7:0] divPrev_r;
	logic syncPrev_r;
	logic firstRead_r;
	logic [31:0] stale_r;
	logic tampPrev_r;
	logic tampEnPrev_r;
	logic [2:0] debCnt_r;
	logic tsSkip_r;
	logic irq_r;
	logic [7:0] perEv_r;
	logic tampLevel;

	// ------------------------------------------------------------
	// Bus decode
	// ------------------------------------------------------------
	wire wr = avs_write & ~waitReq_r;
	wire rdCount = avs_read & ~waitReq_r & (avs_address == rtcq_pkg::ADDR_COUNTER);
	wire wrCtrlA = wr & (avs_address == rtcq_pkg::ADDR_CONTROL_A) & (avs_byteenable == rtcq_pkg::BE_FULL);
	wire wrCtrlB = wr & (avs_address == rtcq_pkg::ADDR_CONTROL_B);
	wire wrEv = wr & (avs_address == rtcq_pkg::ADDR_EVENT_CONTROL);
	wire wrIes = wr & (avs_address == rtcq_pkg::ADDR_INT_ENABLE_SET);
	wire wrIec = wr & (avs_address == rtcq_pkg::ADDR_INT_ENABLE_CLEAR);
	wire wrFlag = wr & (avs_address == rtcq_pkg::ADDR_INT_FLAG);
	wire wrCount = wr & (avs_address == rtcq_pkg::ADDR_COUNTER);
	wire wrCal = wr & (avs_address == rtcq_pkg::ADDR_CALENDAR);
	wire wrTamp = wr & (avs_address == rtcq_pkg::ADDR_TAMPER_CONTROL);
	wire wrGp = wr & (avs_address == rtcq_pkg::ADDR_GENERAL_PURPOSE) & (avs_byteenable == rtcq_pkg::BE_FULL);
	wire wrBk = wr & (avs_address == rtcq_pkg::ADDR_BACKUP) & (avs_byteenable == rtcq_pkg::BE_FULL);

	// ------------------------------------------------------------
	// Control fields
	// ------------------------------------------------------------
	wire runEn = control_a_r[rtcq_pkg::CA_ENABLE];
	wire [1:0] mode = control_a_r[rtcq_pkg::CA_MODE_LO +: 2];
	wire [3:0] presc = control_a_r[rtcq_pkg::CA_PRESC_LO +: 4];
	wire syncEn = control_a_r[rtcq_pkg::CA_SYNC];
	wire debEn = control_b_r[rtcq_pkg::CB_DEBOUNCE];
	wire tampEn = tamper_control_r[rtcq_pkg::TC_ENABLE];
	wire tampRise = tamper_control_r[rtcq_pkg::TC_RISING];
	wire is16 = (mode == rtcq_pkg::MODE_COUNTER_16BIT_MODE);
	wire isCal = (mode == rtcq_pkg::MODE_CALENDAR);

	// Partial writes to the counting registers are dropped rather than merged
	wire countWrOk = is16 ? (avs_byteenable[1:0] == rtcq_pkg::BE_HALF)
		: (avs_byteenable == rtcq_pkg::BE_FULL);
	wire calWrOk = (avs_byteenable == rtcq_pkg::BE_FULL);

	// ------------------------------------------------------------
	// Prescaler and periodic events
	// ------------------------------------------------------------
	// The divider keeps running with the prescaler off while tamper or debounce control is on
	wire prescOn = (presc != rtcq_pkg::PRESC_OFF);
	wire divRun = runEn & (prescOn | tampEn | debEn);
	wire [DIV_BITS-1:0] tickMask = (DIV_BITS'(1) << (presc - 4'h1)) - DIV_BITS'(1);
	wire tick = runEn & prescOn & ((div_r & tickMask) == '0);
	wire [7:0] perRaw = div_r[7:0] & ~divPrev_r;
	wire [31:0] countInc = count_r + 32'h0000_0001;
	wire [15:0] count16Inc = count_r[15:0] + 16'h0001;
	wire overflow = tick & ~isCal & (is16 ? (count_r[15:0] == 16'hFFFF) : (count_r == 32'hFFFF_FFFF));
	wire [31:0] countNext = is16 ? {16'h0000, count16Inc} : countInc;

	// ------------------------------------------------------------
	// Tamper detection
	// ------------------------------------------------------------
	rtcq_sync3 u_sync
	(
		.mclk(mclk),
		.rstn(rstn),
		.pinIn(tamperPin),
		.level(tampLevel)
	);

	// Majority debounce bit is stored and read back but steers nothing
	// tampPrev_r is the accepted level: a new level counts only once it has stood the debounce span,
	// so with debounce on a short glitch raises edgeSeen and pending but never tampHit
	wire debStable = ~debEn | (debCnt_r == 3'(rtcq_pkg::DEBOUNCE_CYCLES));
	wire edgeSeen = tampRise ? (tampLevel & ~tampPrev_r) : (~tampLevel & tampPrev_r);
	wire pending = tampEn & edgeSeen & ~debStable;
	wire spurious = tampEn & ~tampEnPrev_r & tampRise;
	wire tampHit = (tampEn & tampEnPrev_r & edgeSeen & debStable) | spurious;
	wire [31:0] captureVal = isCal ? calendar_r : count_r;

	// ------------------------------------------------------------
	// Interrupt status
	// ------------------------------------------------------------
	wire [rtcq_pkg::IRQ_BITS-1:0] events = {overflow, tampHit, perRaw};
	wire [rtcq_pkg::IRQ_BITS-1:0] flagNxt = (intFlag_r & ~({rtcq_pkg::IRQ_BITS{wrFlag}}
		& avs_writedata[rtcq_pkg::IRQ_BITS-1:0])) | events;

	// ------------------------------------------------------------
	// Read mux
	// ------------------------------------------------------------
	// The first synchronised read after enabling returns the value frozen before enabling
	wire [31:0] countView = (syncEn & firstRead_r) ? stale_r : count_r;
	always_comb
	begin
		case (avs_address)
			rtcq_pkg::ADDR_CONTROL_A: rdata_nxt = control_a_r;
			rtcq_pkg::ADDR_CONTROL_B: rdata_nxt = control_b_r;
			rtcq_pkg::ADDR_EVENT_CONTROL: rdata_nxt = {24'h00_0000, event_control_r};
			rtcq_pkg::ADDR_INT_ENABLE_SET: rdata_nxt = {22'h00_0000, intEn_r};
			rtcq_pkg::ADDR_INT_ENABLE_CLEAR: rdata_nxt = {22'h00_0000, intEn_r};
			rtcq_pkg::ADDR_INT_FLAG: rdata_nxt = {22'h00_0000, intFlag_r};
			rtcq_pkg::ADDR_COUNTER: rdata_nxt = countView;
			rtcq_pkg::ADDR_CALENDAR: rdata_nxt = calendar_r;
			rtcq_pkg::ADDR_TAMPER_CONTROL: rdata_nxt = {30'h0000_0000, tamper_control_r};
			rtcq_pkg::ADDR_TIMESTAMP: rdata_nxt = timestamp_r;
			rtcq_pkg::ADDR_GENERAL_PURPOSE: rdata_nxt = gp_r;
			rtcq_pkg::ADDR_BACKUP: rdata_nxt = backup_r;
			default: rdata_nxt = rtcq_pkg::RESET_WORD;
		endcase
	end

	// ------------------------------------------------------------
	// Bus handshake: one wait cycle, then the access completes
	// ------------------------------------------------------------
	always_ff @(posedge mclk)
	begin
		if (!rstn)
		begin
			waitReq_r <= 1'b1;
			rdata_r <= rtcq_pkg::RESET_WORD;
		end
		else
		begin
			waitReq_r <= ~((avs_read | avs_write) & waitReq_r);
			if (avs_read & waitReq_r)
				rdata_r <= rdata_nxt;
		end
	end

	// ------------------------------------------------------------
	// Control registers
	// ------------------------------------------------------------
	always_ff @(posedge mclk)
	begin
		if (!rstn)
		begin
			control_a_r <= rtcq_pkg::RESET_WORD;
			control_b_r <= rtcq_pkg::RESET_WORD;
			event_control_r <= 8'h00;
			intEn_r <= '0;
			tamper_control_r <= 2'h0;
			gp_r <= rtcq_pkg::RESET_WORD;
			backup_r <= rtcq_pkg::RESET_WORD;
		end
		else
		begin
			if (wrCtrlA)
				control_a_r <= avs_writedata;
			if (wrCtrlB)
				control_b_r <= avs_writedata & 32'h0000_0003;
			if (wrEv)
				event_control_r <= avs_writedata[7:0];
			if (wrIes)
				intEn_r <= intEn_r | avs_writedata[rtcq_pkg::IRQ_BITS-1:0];
			else if (wrIec)
				intEn_r <= intEn_r & ~avs_writedata[rtcq_pkg::IRQ_BITS-1:0];
			if (wrTamp)
				tamper_control_r <= avs_writedata[1:0];
			if (wrGp)
				gp_r <= avs_writedata;
			if (wrBk)
				backup_r <= avs_writedata;
		end
	end

	// ------------------------------------------------------------
	// Counting, read synchronisation, tamper capture, outputs
	// ------------------------------------------------------------
	always_ff @(posedge mclk)
	begin
		if (!rstn)
		begin
			count_r <= rtcq_pkg::RESET_WORD;
			calendar_r <= rtcq_pkg::RESET_WORD;
			div_r <= '0;
			divPrev_r <= 8'h00;
			syncPrev_r <= 1'b0;
			firstRead_r <= 1'b0;
			stale_r <= rtcq_pkg::RESET_WORD;
			tampPrev_r <= 1'b0;
			tampEnPrev_r <= 1'b0;
			debCnt_r <= 3'h0;
			tsSkip_r <= 1'b0;
			timestamp_r <= rtcq_pkg::RESET_WORD;
			intFlag_r <= '0;
			irq_r <= 1'b0;
			perEv_r <= 8'h00;
		end
		else
		begin
			div_r <= divRun ? div_r + DIV_BITS'(1) : div_r;
			divPrev_r <= div_r[7:0];
			if (wrCount & countWrOk & ~isCal)
				count_r <= is16 ? {16'h0000, avs_writedata[15:0]} : avs_writedata;
			else if (tick & ~isCal)
				count_r <= countNext;
			if (wrCal & calWrOk & isCal)
				calendar_r <= avs_writedata;
			else if (tick & isCal)
				calendar_r <= calendar_r + 32'h0000_0001;
			syncPrev_r <= syncEn;
			if (~syncEn)
				stale_r <= count_r;
			if (syncEn & ~syncPrev_r)
				firstRead_r <= 1'b1;
			else if (rdCount)
				firstRead_r <= 1'b0;
			tampEnPrev_r <= tampEn;
			if (tampLevel == tampPrev_r || debStable)
			begin
				tampPrev_r <= tampLevel;
				debCnt_r <= 3'h0;
			end
			else
				debCnt_r <= debCnt_r + 3'h1;
			if (extResetSeen & (pending | (tampEn & edgeSeen)))
				tsSkip_r <= 1'b1;
			else if (tampHit)
				tsSkip_r <= 1'b0;
			if (tampHit & ~tsSkip_r)
				timestamp_r <= captureVal;
			intFlag_r <= flagNxt;
			irq_r <= |(flagNxt & intEn_r);
			perEv_r <= perRaw & event_control_r;
		end
	end

	assign avs_readdata = rdata_r;
	assign avs_waitrequest = waitReq_r;
	assign irq = irq_r;
	assign periodicEvent = perEv_r;
endmodule

// ---- shared/rtcq_pkg.sv ----
/*
 Constants for the real-time counter with its tamper input and periodic events.
 Assumes a 32-bit Avalon-MM register port with byte enables and one 100 MHz clock.
*/
package rtcq_pkg;
	// ------------------------------------------------------------
	// Register byte addresses
	// ------------------------------------------------------------
	localparam logic [5:0] ADDR_CONTROL_A = 6'h00;
	localparam logic [5:0] ADDR_CONTROL_B = 6'h04;
	localparam logic [5:0] ADDR_EVENT_CONTROL = 6'h08;
	localparam logic [5:0] ADDR_INT_ENABLE_SET = 6'h0C;
	localparam logic [5:0] ADDR_INT_ENABLE_CLEAR = 6'h10;
	localparam logic [5:0] ADDR_INT_FLAG = 6'h14;
	localparam logic [5:0] ADDR_COUNTER = 6'h18;
	localparam logic [5:0] ADDR_CALENDAR = 6'h1C;
	localparam logic [5:0] ADDR_TAMPER_CONTROL = 6'h20;
	localparam logic [5:0] ADDR_TIMESTAMP = 6'h24;
	localparam logic [5:0] ADDR_GENERAL_PURPOSE = 6'h28;
	localparam logic [5:0] ADDR_BACKUP = 6'h2C;
	// ------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------
	localparam int CA_ENABLE = 0;
	localparam int CA_MODE_LO = 2;
	localparam int CA_PRESC_LO = 8;
	localparam int CA_SYNC = 15;
	localparam int CB_DEBOUNCE = 0;
	localparam int CB_MAJORITY = 1;
	localparam int TC_ENABLE = 0;
	localparam int TC_RISING = 1;
	localparam int IF_TAMPER = 8;
	localparam int IF_OVERFLOW = 9;
	localparam int IRQ_BITS = 10;
	// ------------------------------------------------------------
	// Modes and reset values
	// ------------------------------------------------------------
	typedef enum logic [1:0]
	{
		MODE_COUNTER_32BIT_MODE = 2'b00,
		MODE_COUNTER_16BIT_MODE = 2'b01,
		MODE_CALENDAR = 2'b10,
		MODE_SPARE = 2'b11
	} rtcq_mode_t;
	localparam logic [31:0] RESET_WORD = 32'h0000_0000;
	localparam logic [3:0] BE_FULL = 4'hF;
	localparam logic [1:0] BE_HALF = 2'h3;
	localparam logic [3:0] PRESC_OFF = 4'h0;
	// ------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------
	localparam int CLOCK_MHZ = 100;
	localparam int DEBOUNCE_NS = 30;
	localparam int DEBOUNCE_CYCLES = (DEBOUNCE_NS * CLOCK_MHZ + 999) / 1000;
endpackage

// ---- hdl/rtcq_sync3.sv ----
/*
 Three-stage synchroniser for the tamper pin.
 Assumes an asynchronous input; the level moves only when stages two and three agree.
*/
`timescale 1ns/1ps
module rtcq_sync3
(
	input wire logic mclk,
	input wire logic rstn,
	input wire logic pinIn,
	output logic level
);
	logic stage1_r;
	logic stage2_r;
	logic stage3_r;
	logic level_r;

	// Stage one feeds stage two only
	always_ff @(posedge mclk)
	begin
		if (!rstn)
		begin
			stage1_r <= 1'b0;
			stage2_r <= 1'b0;
			stage3_r <= 1'b0;
			level_r <= 1'b0;
		end
		else
		begin
			stage1_r <= pinIn;
			stage2_r <= stage1_r;
			stage3_r <= stage2_r;
			if (stage2_r == stage3_r)
				level_r <= stage3_r;
		end
	end

	assign level = level_r;
endmodule

// ---- tb/rtcq_monitor.sv ----
/*
 Checker for rtcq_top: bus handshake, read values, tamper interrupt and periodic pulses.
 Assumes it is bound to rtcq_top and sees only its ports.
*/
`timescale 1ns/1ps
module rtcq_monitor
(
	input wire logic mclk,
	input wire logic rstn,
	input wire logic [5:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	input wire logic [31:0] avs_readdata,
	input wire logic avs_waitrequest,
	input wire logic tamperPin,
	input wire logic extResetSeen,
	input wire logic irq,
	input wire logic [7:0] periodicEvent
);
	// ----------------------------------------
	// Shadow of what software has written
	// ----------------------------------------
	logic wrDone;
	logic rdDone;
	logic [31:0] gpShadow_r;
	logic tamperMask_r;
	logic tamperOn_r;
	assign wrDone = avs_write && !avs_waitrequest;
	assign rdDone = avs_read && !avs_waitrequest;
	always_ff @(posedge mclk)
	begin
		if (!rstn)
		begin
			gpShadow_r <= 32'h0000_0000;
			tamperMask_r <= 1'b0;
			tamperOn_r <= 1'b0;
		end
		else if (wrDone)
		begin
			if (avs_address == rtcq_pkg::ADDR_GENERAL_PURPOSE && avs_byteenable == rtcq_pkg::BE_FULL)
				gpShadow_r <= avs_writedata;
			if (avs_address == rtcq_pkg::ADDR_INT_ENABLE_SET && avs_writedata[8])
				tamperMask_r <= 1'b1;
			if (avs_address == rtcq_pkg::ADDR_INT_ENABLE_CLEAR && avs_writedata[8])
				tamperMask_r <= 1'b0;
			if (avs_address == rtcq_pkg::ADDR_TAMPER_CONTROL)
				tamperOn_r <= avs_writedata[0];
		end
	end
	// ----------------------------------------
	// Properties
	// ----------------------------------------
	default clocking @(posedge mclk); endclocking
	default disable iff (!rstn);
	chk_wait_answer: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
		else $error("request not answered in one cycle");
	chk_wait_single: assert property (!avs_waitrequest |=> avs_waitrequest)
		else $error("waitrequest low for more than one cycle");
	chk_reset_quiet: assert property ($rose(rstn) |-> avs_waitrequest && !irq && periodicEvent == 8'h00)
		else $error("outputs not idle after reset");
	chk_unmapped_zero: assert property (rdDone && avs_address > rtcq_pkg::ADDR_BACKUP |-> avs_readdata == 32'h0000_0000)
		else $error("unmapped read not zero");
	chk_partial_drop: assert property (rdDone && avs_address == rtcq_pkg::ADDR_GENERAL_PURPOSE |-> avs_readdata == gpShadow_r)
		else $error("narrow write changed a full word register");
	chk_spurious_flag: assert property (wrDone && avs_address == rtcq_pkg::ADDR_TAMPER_CONTROL && avs_writedata[1:0] == 2'b11
		&& !tamperOn_r && tamperMask_r |-> ##[1:4] irq)
		else $error("enable in rising mode raised no tamper interrupt");
	chk_event_pulse: assert property (periodicEvent != 8'h00 |=> (periodicEvent & $past(periodicEvent)) == 8'h00)
		else $error("periodic event longer than one cycle");
endmodule
bind rtcq_top rtcq_monitor rtcq_monitor_i (.mclk, .rstn, .avs_address, .avs_read, .avs_write, .avs_writedata,
	.avs_byteenable, .avs_readdata, .avs_waitrequest, .tamperPin, .extResetSeen, .irq, .periodicEvent);

// ---- tb/testbench.sv ----
/*
 Self-checking bench for rtcq_top through its Avalon-MM port, tamper pin and event outputs.
 Assumes the package and the checker are compiled first; one 100 MHz clock.
*/
`timescale 1ns/1ps
module testbench;
	logic mclk;
	logic rstn;
	logic [5:0] avs_address;
	logic avs_read;
	logic avs_write;
	logic [31:0] avs_writedata;
	logic [3:0] avs_byteenable;
	logic [31:0] avs_readdata;
	logic avs_waitrequest;
	logic tamperPin;
	logic extResetSeen;
	logic irq;
	logic [7:0] periodicEvent;
	int errCount;
	int comparisons;
	int evCnt = 0;
	logic [31:0] v0;
	logic [31:0] v1;
	logic [31:0] v2;
	rtcq_top #(.DIV_BITS(16)) rtcq_top_i (.mclk, .rstn, .avs_address, .avs_read, .avs_write, .avs_writedata,
		.avs_byteenable, .avs_readdata, .avs_waitrequest, .tamperPin, .extResetSeen, .irq, .periodicEvent);
	// ----------------------------------------
	// Bus tasks and checks
	// ----------------------------------------
	task wr(input logic [5:0] a, input logic [31:0] d, input logic [3:0] b);
		@(posedge mclk);
		avs_address <= a;
		avs_writedata <= d;
		avs_byteenable <= b;
		avs_write <= 1'b1;
		// Waitrequest is read at the rising edge, before the slave's own update lands
		do @(posedge mclk); while (avs_waitrequest !== 1'b0);
		avs_write <= 1'b0;
	endtask
	task rd(input logic [5:0] a, output logic [31:0] d);
		@(posedge mclk);
		avs_address <= a;
		avs_read <= 1'b1;
		do @(posedge mclk); while (avs_waitrequest !== 1'b0);
		d = avs_readdata;
		avs_read <= 1'b0;
	endtask
	task chk(input logic [31:0] g, input logic [31:0] e);
		comparisons++;
		if (g !== e)
		begin
			errCount++;
			$display("FAIL t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task pin(input logic lvl, input logic ext);
		// External reset is held across the whole detection so it overlaps the edge
		tamperPin <= lvl;
		if (ext)
			extResetSeen <= 1'b1;
		repeat (9) @(posedge mclk);
		if (ext)
			extResetSeen <= 1'b0;
	endtask
	task completeRun;
		$display("errors %0d comparisons %0d", errCount, comparisons);
		if (errCount == 0 && comparisons > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	// ----------------------------------------
	// Clock, watchdog, event counter
	// ----------------------------------------
	initial
	begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end
	initial
	begin
		#200000;
		errCount++;
		completeRun;
	end
	always @(posedge mclk)
		if (periodicEvent !== 8'h00)
			evCnt = evCnt + 1;
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	initial
	begin
		{rstn, avs_read, avs_write, extResetSeen, errCount, comparisons} = '0;
		{avs_address, avs_writedata, avs_byteenable} = '0;
		tamperPin = 1'b1;
		repeat (10) @(posedge mclk);
		rstn <= 1'b1;
		for (int i = 0; i < 2; i++)
		begin
			wr(rtcq_pkg::ADDR_GENERAL_PURPOSE + 6'(4 * i), 32'h1234_5678, 4'hF);
			wr(rtcq_pkg::ADDR_GENERAL_PURPOSE + 6'(4 * i), 32'hFFFF_FFFF, 4'h3);
			rd(rtcq_pkg::ADDR_GENERAL_PURPOSE + 6'(4 * i), v0);
			chk(v0, 32'h1234_5678);
		end
		wr(6'h30, 32'hFFFF_FFFF, 4'hF);
		rd(6'h30, v0);
		chk(v0, 32'h0000_0000);
		// Counter stopped so narrow writes can be judged by readback
		wr(rtcq_pkg::ADDR_CONTROL_A, 32'h0000_0000, 4'hF);
		wr(rtcq_pkg::ADDR_COUNTER, 32'h0000_0100, 4'hF);
		wr(rtcq_pkg::ADDR_COUNTER, 32'h0000_00FF, 4'h1);
		rd(rtcq_pkg::ADDR_COUNTER, v0);
		chk(v0, 32'h0000_0100);
		wr(rtcq_pkg::ADDR_CONTROL_A, 32'h0000_0004, 4'hF);
		wr(rtcq_pkg::ADDR_COUNTER, 32'h0000_0055, 4'h1);
		rd(rtcq_pkg::ADDR_COUNTER, v0);
		chk(v0, 32'h0000_0100);
		wr(rtcq_pkg::ADDR_COUNTER, 32'h0000_0055, 4'h3);
		rd(rtcq_pkg::ADDR_COUNTER, v0);
		chk(v0, 32'h0000_0055);
		wr(rtcq_pkg::ADDR_CONTROL_A, 32'h0000_0008, 4'hF);
		wr(rtcq_pkg::ADDR_CALENDAR, 32'h0000_00A5, 4'hF);
		wr(rtcq_pkg::ADDR_CALENDAR, 32'h0000_00FF, 4'h3);
		rd(rtcq_pkg::ADDR_CALENDAR, v0);
		chk(v0, 32'h0000_00A5);
		// Live reads three cycles apart advance by three at prescaler 1
		wr(rtcq_pkg::ADDR_CONTROL_A, 32'h0000_0101, 4'hF);
		repeat (40) @(posedge mclk);
		wr(rtcq_pkg::ADDR_CONTROL_A, 32'h0000_8101, 4'hF);
		rd(rtcq_pkg::ADDR_COUNTER, v0);
		rd(rtcq_pkg::ADDR_COUNTER, v1);
		rd(rtcq_pkg::ADDR_COUNTER, v2);
		chk(v2 - v1, 32'h0000_0003);
		chk(32'(v1 - v0 == 32'h0000_0003), 32'h0000_0000);
		wr(rtcq_pkg::ADDR_CONTROL_A, 32'h0000_0000, 4'hF);
		wr(rtcq_pkg::ADDR_INT_ENABLE_SET, 32'h0000_0100, 4'hF);
		wr(rtcq_pkg::ADDR_INT_FLAG, 32'h0000_03FF, 4'hF);
		wr(rtcq_pkg::ADDR_TAMPER_CONTROL, 32'h0000_0003, 4'hF);
		rd(rtcq_pkg::ADDR_INT_FLAG, v0);
		chk(v0 & 32'h0000_0100, 32'h0000_0100);
		@(negedge mclk);
		chk(32'(irq), 32'h0000_0001);
		wr(rtcq_pkg::ADDR_INT_FLAG, 32'h0000_0100, 4'hF);
		@(negedge mclk);
		chk(32'(irq), 32'h0000_0000);
		wr(rtcq_pkg::ADDR_INT_ENABLE_CLEAR, 32'h0000_0100, 4'hF);
		wr(rtcq_pkg::ADDR_TAMPER_CONTROL, 32'h0000_0000, 4'hF);
		wr(rtcq_pkg::ADDR_TAMPER_CONTROL, 32'h0000_0003, 4'hF);
		@(negedge mclk);
		chk(32'(irq), 32'h0000_0000);
		// Two-cycle glitch: a majority vote would pass it, plain debounce must not
		wr(rtcq_pkg::ADDR_CONTROL_B, 32'h0000_0003, 4'hF);
		wr(rtcq_pkg::ADDR_TAMPER_CONTROL, 32'h0000_0001, 4'hF);
		wr(rtcq_pkg::ADDR_INT_FLAG, 32'h0000_03FF, 4'hF);
		tamperPin <= 1'b0;
		repeat (2) @(posedge mclk);
		pin(1'b1, 1'b0);
		rd(rtcq_pkg::ADDR_INT_FLAG, v0);
		chk(v0 & 32'h0000_0100, 32'h0000_0000);
		wr(rtcq_pkg::ADDR_CONTROL_B, 32'h0000_0000, 4'hF);
		wr(rtcq_pkg::ADDR_CONTROL_A, 32'h0000_0109, 4'hF);
		rd(rtcq_pkg::ADDR_TIMESTAMP, v0);
		pin(1'b0, 1'b0);
		rd(rtcq_pkg::ADDR_TIMESTAMP, v1);
		chk(32'(v1 != v0), 32'h0000_0001);
		pin(1'b1, 1'b0);
		pin(1'b0, 1'b1);
		rd(rtcq_pkg::ADDR_TIMESTAMP, v1);
		pin(1'b1, 1'b0);
		pin(1'b0, 1'b0);
		rd(rtcq_pkg::ADDR_TIMESTAMP, v2);
		chk(v2, v1);
		rd(rtcq_pkg::ADDR_CALENDAR, v0);
		wr(rtcq_pkg::ADDR_BACKUP, v0, 4'hF);
		rd(rtcq_pkg::ADDR_BACKUP, v1);
		chk(v1, v0);
		// Prescaler off with tamper on still fires periodic events
		wr(rtcq_pkg::ADDR_CONTROL_A, 32'h0000_0001, 4'hF);
		wr(rtcq_pkg::ADDR_EVENT_CONTROL, 32'h0000_00FF, 4'hF);
		wr(rtcq_pkg::ADDR_INT_ENABLE_SET, 32'h0000_00FF, 4'hF);
		v0 = 32'(evCnt);
		repeat (300) @(posedge mclk);
		chk(32'(32'(evCnt) != v0), 32'h0000_0001);
		rd(rtcq_pkg::ADDR_INT_FLAG, v0);
		chk(32'(v0[7:0] != 8'h00), 32'h0000_0001);
		@(negedge mclk);
		chk(32'(irq), 32'h0000_0001);
		wr(rtcq_pkg::ADDR_EVENT_CONTROL, 32'h0000_0000, 4'hF);
		wr(rtcq_pkg::ADDR_INT_ENABLE_CLEAR, 32'h0000_00FF, 4'hF);
		wr(rtcq_pkg::ADDR_INT_FLAG, 32'h0000_03FF, 4'hF);
		v0 = 32'(evCnt);
		repeat (300) @(posedge mclk);
		chk(32'(evCnt), v0);
		@(negedge mclk);
		chk(32'(irq), 32'h0000_0000);
		completeRun;
	end
endmodule
